//--- lcd_command_decoder.v
// What this block does
// - AE/AF switch display off or on.
// - 01xxxxxx loads display start line.
// - 1011xxxx loads page address.
// - 0001/0000 load column high/low nibble.
// - Data write stores byte at page/column.
// - Data read returns byte at page/column.
// - Bit 0 chooses segment order normal/reversed.
// - A6/A7 choose normal or inverted display.
// - A4/A5 force all pixels on, memory kept.
// - A2/A3 choose bias 1/9 or 1/7.
// - Read-modify-write: writes advance; end restores column.
// - 1100x*** sets common scan direction.
// - 00101xxx loads power circuit state.
// - 00100xxx loads resistor ratio.
// - 81 then byte loads six-bit drive level.
// - AC/AD indicator; on takes blink byte.
// - A8/A9 power save; E1 restores.
// - 0011xxxx loads reversal line count.
// - E4 cancels line reversal, keeps count.
// - AB starts built-in oscillator.
// - 1111xxxx test state; reset or no-op leave.
// - Pending two-byte command accepts only argument.
// - Blink field: off, half, one second, on.
// - Line count 1..15 means 2..16 lines.
// - Power bits: booster, regulator, follower.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defines.vh"
module lcd_command_decoder #(
    parameter PAGE_W = 4,
    parameter COL_W = 8,
    parameter FIFO_DEPTH = 8
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire chip_reset_n_in,
    input wire wr_stb_in,
    input wire rd_stb_in,
    input wire cmd_data_select_in,
    input wire [7:0] wr_data_in,
    output wire wr_ready_out,
    output reg [7:0] rd_data_out,
    output reg rd_valid_out,
    output wire mem_we_out,
    output wire [PAGE_W+COL_W-1:0] mem_waddr_out,
    output wire [7:0] mem_wdata_out,
    input wire mem_wready_in,
    output wire [PAGE_W+COL_W-1:0] mem_raddr_out,
    input wire [7:0] mem_rdata_in,
    output wire display_on_out,
    output wire [5:0] start_line_out,
    output wire [PAGE_W-1:0] page_addr_out,
    output wire [COL_W-1:0] col_addr_out,
    output wire segment_reverse_out,
    output wire disp_invert_out,
    output wire all_on_out,
    output wire bias_1_7_out,
    output wire common_reverse_out,
    output wire booster_en_out,
    output wire regulator_en_out,
    output wire follower_en_out,
    output wire [2:0] resistor_ratio_out,
    output wire [5:0] lcd_drive_level_out,
    output wire indicator_on_out,
    output wire [1:0] indicator_blink_out,
    output wire power_save_out,
    output wire sleep_out,
    output wire osc_on_out,
    output wire [3:0] nline_count_out,
    output wire nline_active_out,
    output wire test_mode_out,
    output wire rmw_active_out
);
    ////////////////////////////////////////////////////////////////////////
    // Decoder states, one-hot.
    localparam ST_IDLE = 4'b0001;
    localparam ST_LEVEL = 4'b0010;
    localparam ST_IND = 4'b0100;
    localparam ST_TEST = 4'b1000;

    reg [3:0] state_q, state_d;
    reg disp_on_q, mirror_q, inv_q, all_on_q, bias_q, scan_rev_q;
    reg [5:0] start_q, level_q;
    reg [PAGE_W-1:0] page_q;
    reg [COL_W-1:0] col_q, rmw_col_q;
    reg [2:0] pwr_q, ratio_q;
    reg ind_on_q, save_q, sleep_q, osc_q, nline_act_q, rmw_q;
    reg [1:0] blink_q;
    reg [3:0] nline_q;
    wire rst_all, cmd_wr, data_wr, data_rd, fifo_in_ready;

    // Match a byte against a prefix under a mask.
    function match;
        input [7:0] b;
        input [7:0] pfx;
        input [7:0] msk;
        begin
            match = ((b & msk) == pfx);
        end
    endfunction

    // While an argument is pending, the reset code is taken as that argument.
    assign cmd_wr = wr_stb_in && !cmd_data_select_in;
    assign rst_all = !chip_reset_n_in || (cmd_wr && wr_data_in == `LCD_CMD_RESET
        && state_q != ST_LEVEL && state_q != ST_IND);
    // A data write is only taken when the queue has room; the host sees ready.
    assign data_wr = wr_stb_in && cmd_data_select_in && fifo_in_ready;
    assign data_rd = rd_stb_in && cmd_data_select_in;
    assign wr_ready_out = !cmd_data_select_in || fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////
    // Data writes queue up with their address so memory back-pressure stalls the host.
    lcd_fifo #(
        .WIDTH(PAGE_W + COL_W + 8),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_wfifo (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(data_wr),
        .in_ready_out(fifo_in_ready),
        .in_data_in({page_q, col_q, wr_data_in}),
        .out_valid_out(mem_we_out),
        .out_ready_in(mem_wready_in),
        .out_data_out({mem_waddr_out, mem_wdata_out})
    );

    // Reads see the current address; memory is combinational on its read port.
    assign mem_raddr_out = {page_q, col_q};

    // Read data is registered for one cycle. Reads may overtake queued writes.
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= data_rd;
            if (data_rd) begin
                rd_data_out <= mem_rdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the two-byte and test states.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_wr && wr_data_in == `LCD_CMD_LEVEL_MODE) begin
                    state_d = ST_LEVEL;
                end else if (cmd_wr && wr_data_in == `LCD_CMD_IND_ON) begin
                    state_d = ST_IND;
                end else if (cmd_wr && match(wr_data_in, `LCD_PFX_TEST, `LCD_MSK_NIB)) begin
                    state_d = ST_TEST;
                end
            end
            ST_LEVEL, ST_IND: begin
                if (cmd_wr) begin
                    state_d = ST_IDLE;
                end
            end
            ST_TEST: begin
                if (cmd_wr && wr_data_in == `LCD_CMD_NO_OP) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Initial control values shared by every reset; only constants are loaded.
    task load_initial;
        begin
            state_q <= ST_IDLE;
            disp_on_q <= 1'b0;
            start_q <= 6'h00;
            page_q <= {PAGE_W{1'b0}};
            col_q <= {COL_W{1'b0}};
            mirror_q <= 1'b0;
            inv_q <= 1'b0;
            all_on_q <= 1'b0;
            bias_q <= 1'b0;
            scan_rev_q <= 1'b0;
            pwr_q <= 3'h0;
            ratio_q <= `LCD_RST_RATIO;
            level_q <= `LCD_RST_LEVEL;
            ind_on_q <= 1'b0;
            blink_q <= 2'h0;
            save_q <= 1'b0;
            sleep_q <= 1'b0;
            nline_q <= `LCD_RST_NLINE;
            nline_act_q <= 1'b0;
            rmw_q <= 1'b0;
        end
    endtask

    // Command register file. Pending and test states block ordinary decode.
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            load_initial;
            osc_q <= 1'b0;
            rmw_col_q <= {COL_W{1'b0}};
        end else if (rst_all) begin
            // Pin or command reset keeps the oscillator running.
            load_initial;
        end else begin
            state_q <= state_d;
            // Only writes advance the column in read-modify-write.
            if (data_wr && rmw_q) begin
                col_q <= col_q + 1'b1;
            end
            if (cmd_wr && state_q == ST_LEVEL) begin
                level_q <= wr_data_in[5:0];
            end else if (cmd_wr && state_q == ST_IND) begin
                blink_q <= wr_data_in[1:0];
            end else if (cmd_wr && state_q == ST_IDLE) begin
                case (wr_data_in)
                    `LCD_CMD_DISP_OFF, `LCD_CMD_DISP_ON: disp_on_q <= wr_data_in[0];
                    `LCD_CMD_MAP_NORM, `LCD_CMD_MAP_REV: mirror_q <= wr_data_in[0];
                    `LCD_CMD_INV_NORM, `LCD_CMD_INV_ON: inv_q <= wr_data_in[0];
                    `LCD_CMD_ALL_NORM, `LCD_CMD_ALL_ON: all_on_q <= wr_data_in[0];
                    `LCD_CMD_BIAS_9, `LCD_CMD_BIAS_7: bias_q <= wr_data_in[0];
                    `LCD_CMD_IND_OFF, `LCD_CMD_IND_ON: ind_on_q <= wr_data_in[0];
                    `LCD_CMD_SAVE_STBY, `LCD_CMD_SAVE_SLEEP: begin
                        save_q <= 1'b1;
                        sleep_q <= wr_data_in[0];
                    end
                    `LCD_CMD_SAVE_EXIT: begin
                        // Stored settings were never touched, so leaving restores them.
                        save_q <= 1'b0;
                        sleep_q <= 1'b0;
                    end
                    `LCD_CMD_OSC_ON: osc_q <= 1'b1;
                    `LCD_CMD_NLINE_OFF: nline_act_q <= 1'b0;
                    `LCD_CMD_RMW: begin
                        rmw_q <= 1'b1;
                        rmw_col_q <= col_q;
                    end
                    `LCD_CMD_RMW_END: begin
                        rmw_q <= 1'b0;
                        col_q <= rmw_col_q;
                    end
                    default: begin
                        if (match(wr_data_in, `LCD_PFX_START, `LCD_MSK_START)) begin
                            start_q <= wr_data_in[5:0];
                        end else if (match(wr_data_in, `LCD_PFX_PAGE, `LCD_MSK_NIB)) begin
                            page_q <= wr_data_in[PAGE_W-1:0];
                        end else if (match(wr_data_in, `LCD_PFX_COLH, `LCD_MSK_NIB)) begin
                            col_q[COL_W-1:COL_W-4] <= wr_data_in[3:0];
                        end else if (match(wr_data_in, `LCD_PFX_COLL, `LCD_MSK_NIB)) begin
                            col_q[3:0] <= wr_data_in[3:0];
                        end else if (match(wr_data_in, `LCD_PFX_SCAN, `LCD_MSK_NIB)) begin
                            scan_rev_q <= wr_data_in[3];
                        end else if (match(wr_data_in, `LCD_PFX_PWR, `LCD_MSK_3B)) begin
                            pwr_q <= wr_data_in[2:0];
                        end else if (match(wr_data_in, `LCD_PFX_RATIO, `LCD_MSK_3B)) begin
                            ratio_q <= wr_data_in[2:0];
                        end else if (match(wr_data_in, `LCD_PFX_NLINE, `LCD_MSK_NIB)) begin
                            nline_q <= wr_data_in[3:0];
                            nline_act_q <= (wr_data_in[3:0] != 4'h0);
                        end
                        // Anything else, no-op included, leaves the settings alone.
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs; power save forces the drive system off without losing settings.
    assign display_on_out = disp_on_q && !save_q;
    assign start_line_out = start_q;
    assign page_addr_out = page_q;
    assign col_addr_out = col_q;
    assign segment_reverse_out = mirror_q;
    assign disp_invert_out = inv_q;
    assign all_on_out = all_on_q;
    assign bias_1_7_out = bias_q;
    assign common_reverse_out = scan_rev_q;
    assign booster_en_out = pwr_q[2] && !save_q;
    assign regulator_en_out = pwr_q[1] && !save_q;
    assign follower_en_out = pwr_q[0] && !save_q;
    assign resistor_ratio_out = ratio_q;
    assign lcd_drive_level_out = level_q;
    assign indicator_on_out = ind_on_q && !sleep_q;
    assign indicator_blink_out = blink_q;
    assign power_save_out = save_q;
    assign sleep_out = sleep_q;
    assign osc_on_out = osc_q && !sleep_q;
    assign nline_count_out = nline_q;
    assign nline_active_out = nline_act_q;
    assign test_mode_out = (state_q == ST_TEST);
    assign rmw_active_out = rmw_q;
endmodule // lcd_command_decoder
`default_nettype wire

//--- lcd_command_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_command_decoder_checker #(
    parameter PAGE_W = 4,
    parameter COL_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic chip_reset_n_in,
    input wire logic wr_stb_in,
    input wire logic rd_stb_in,
    input wire logic cmd_data_select_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_ready_out,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic mem_we_out,
    input wire logic [PAGE_W+COL_W-1:0] mem_waddr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic display_on_out,
    input wire logic [5:0] start_line_out,
    input wire logic [PAGE_W-1:0] page_addr_out,
    input wire logic [COL_W-1:0] col_addr_out,
    input wire logic power_save_out,
    input wire logic [5:0] lcd_drive_level_out,
    input wire logic test_mode_out,
    input wire logic rmw_active_out
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the two-byte state, so a pending argument is never read as a command.
    logic [1:0] pend_q;
    wire cmd_w = wr_stb_in && !cmd_data_select_in && chip_reset_n_in;
    wire cmd_ok = cmd_w && pend_q == 2'h0 && !test_mode_out;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in)
            pend_q <= 2'h0;
        else if (cmd_ok)
            pend_q <= {wr_data_in == 8'had, wr_data_in == 8'h81};
        else if (!chip_reset_n_in || cmd_w)
            pend_q <= 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One clock and one reset for every check.
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    disp_switch_a:
        assert property (cmd_ok && wr_data_in[7:1] == 7'h57 |=>
            display_on_out == ($past(wr_data_in[0]) && !power_save_out))
        else $error("display switch not applied");
    start_line_a:
        assert property (cmd_ok && wr_data_in[7:6] == 2'h1 |=>
            start_line_out == $past(wr_data_in[5:0])) else $error("start line wrong");
    page_set_a:
        assert property (cmd_ok && wr_data_in[7:4] == 4'hb |=>
            page_addr_out == $past(wr_data_in[PAGE_W-1:0])) else $error("page wrong");
    level_arg_a:
        assert property (pend_q[0] && cmd_w |=>
            lcd_drive_level_out == $past(wr_data_in[5:0])) else $error("level wrong");
    mem_queue_a:
        assert property (wr_stb_in && cmd_data_select_in && wr_ready_out && !mem_we_out
            |=> mem_we_out && mem_wdata_out == $past(wr_data_in)
            && mem_waddr_out == {$past(page_addr_out), $past(col_addr_out)})
        else $error("queued write wrong");
    read_ret_a:
        assert property (rd_stb_in && cmd_data_select_in |=>
            rd_valid_out && rd_data_out == $past(mem_rdata_in)) else $error("read wrong");
    rmw_step_a:
        assert property (rmw_active_out && wr_stb_in && cmd_data_select_in && wr_ready_out
            && chip_reset_n_in |=> col_addr_out == $past(col_addr_out) + 1'b1)
        else $error("column did not step");
    rmw_read_a:
        assert property (rmw_active_out && rd_stb_in && !wr_stb_in && chip_reset_n_in
            |=> $stable(col_addr_out)) else $error("column moved on read");
    test_exit_a:
        assert property (test_mode_out && cmd_w |=> test_mode_out ==
            ($past(wr_data_in) != 8'he2 && $past(wr_data_in) != 8'he3))
        else $error("test state wrong");
    cover property (pend_q[0] && cmd_w);
    cover property (!wr_ready_out);
    cover property (rmw_active_out && wr_stb_in && cmd_data_select_in);
endmodule // lcd_command_decoder_checker
bind lcd_command_decoder lcd_command_decoder_checker #(.PAGE_W(PAGE_W), .COL_W(COL_W)) i_chk (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .chip_reset_n_in(chip_reset_n_in),
    .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .cmd_data_select_in(cmd_data_select_in),
    .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .mem_we_out(mem_we_out), .mem_waddr_out(mem_waddr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
    .display_on_out(display_on_out), .start_line_out(start_line_out),
    .page_addr_out(page_addr_out), .col_addr_out(col_addr_out),
    .power_save_out(power_save_out), .lcd_drive_level_out(lcd_drive_level_out),
    .test_mode_out(test_mode_out), .rmw_active_out(rmw_active_out));
`default_nettype wire

//--- lcd_command_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_command_decoder_test;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic chip_reset_n_in = 1'b1;
    logic wr_stb_in = 1'b0;
    logic rd_stb_in = 1'b0;
    logic cmd_data_select_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic stall = 1'b0;
    wire [7:0] rd_data_out, mem_wdata_out, mem_rdata_in, col_addr_out;
    wire [5:0] start_line_out, lcd_drive_level_out;
    wire [11:0] mem_waddr_out, mem_raddr_out;
    wire [3:0] page_addr_out, nline_count_out;
    wire [2:0] resistor_ratio_out;
    wire [1:0] indicator_blink_out;
    wire wr_ready_out, rd_valid_out, mem_we_out, mem_wready_in, display_on_out;
    wire disp_invert_out, all_on_out, bias_1_7_out, common_reverse_out, booster_en_out;
    wire regulator_en_out, follower_en_out, indicator_on_out, power_save_out, sleep_out;
    wire osc_on_out, nline_active_out, test_mode_out, rmw_active_out, segment_reverse_out;
    wire [4:0] save_view = {power_save_out, sleep_out, display_on_out, booster_en_out, osc_on_out};
    integer failures = 0;
    integer checked = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////////////
    lcd_command_decoder i_lcd_command_decoder (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .chip_reset_n_in(chip_reset_n_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
        .cmd_data_select_in(cmd_data_select_in), .wr_data_in(wr_data_in),
        .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .mem_we_out(mem_we_out), .mem_waddr_out(mem_waddr_out), .mem_wdata_out(mem_wdata_out),
        .mem_wready_in(mem_wready_in), .mem_raddr_out(mem_raddr_out),
        .mem_rdata_in(mem_rdata_in), .display_on_out(display_on_out),
        .start_line_out(start_line_out), .page_addr_out(page_addr_out),
        .col_addr_out(col_addr_out), .segment_reverse_out(segment_reverse_out),
        .disp_invert_out(disp_invert_out), .all_on_out(all_on_out), .bias_1_7_out(bias_1_7_out),
        .common_reverse_out(common_reverse_out), .booster_en_out(booster_en_out),
        .regulator_en_out(regulator_en_out), .follower_en_out(follower_en_out),
        .resistor_ratio_out(resistor_ratio_out), .lcd_drive_level_out(lcd_drive_level_out),
        .indicator_on_out(indicator_on_out), .indicator_blink_out(indicator_blink_out),
        .power_save_out(power_save_out), .sleep_out(sleep_out), .osc_on_out(osc_on_out),
        .nline_count_out(nline_count_out), .nline_active_out(nline_active_out),
        .test_mode_out(test_mode_out), .rmw_active_out(rmw_active_out));
    lcd_mem_model i_lcd_mem_model (.clk_sys_in(clk_sys_in), .stall_in(stall),
        .we_in(mem_we_out), .waddr_in(mem_waddr_out), .wdata_in(mem_wdata_out),
        .wready_out(mem_wready_in), .raddr_in(mem_raddr_out), .rdata_out(mem_rdata_in));
    ////////////////////////////////////////////////////////////////////////
    // Bus cycles: one strobe cycle each, driven and released on falling edges.
    task automatic put(input logic sel, input logic [7:0] b);
        @(negedge clk_sys_in);
        cmd_data_select_in = sel;
        wr_data_in = b;
        wr_stb_in = 1'b1;
        @(negedge clk_sys_in);
        wr_stb_in = 1'b0;
    endtask
    task automatic cmd(input logic [7:0] b);
        put(1'b0, b);
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        @(negedge clk_sys_in);
        cmd_data_select_in = 1'b1;
        rd_stb_in = 1'b1;
        @(negedge clk_sys_in);
        rd_stb_in = 1'b0;
        chk("rd_valid_out", 12'h1, rd_valid_out);
        chk("rd_data_out", exp, rd_data_out);
    endtask
    // Reads bypass the queue, so the queue must be empty before a read-back.
    task automatic drain;
        for (int n = 0; n < 50 && mem_we_out !== 1'b0; n++)
            @(negedge clk_sys_in);
        chk("mem_we_out", 12'h0, mem_we_out);
    endtask
    task automatic test_done;
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence of command and data traffic.
    initial begin
        repeat (12) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        chk("level", 12'h20, lcd_drive_level_out);
        for (int i = 0; i < 2; i++) begin
            cmd(8'hae + i[7:0]);
            chk("display_on", i[11:0], display_on_out);
            cmd(8'ha0 + i[7:0]);
            chk("segment_reverse", i[11:0], segment_reverse_out);
            cmd(8'ha6 + i[7:0]);
            chk("disp_invert", i[11:0], disp_invert_out);
            cmd(8'ha4 + i[7:0]);
            chk("all_on", i[11:0], all_on_out);
            cmd(8'ha2 + i[7:0]);
            chk("bias", i[11:0], bias_1_7_out);
            cmd({4'hc, i[0], 3'h5});
            chk("common_reverse", i[11:0], common_reverse_out);
        end
        cmd(8'h7f);
        chk("start_line", 12'h3f, start_line_out);
        cmd(8'hb5);
        chk("page", 12'h5, page_addr_out);
        cmd(8'h1a);
        cmd(8'h03);
        chk("col", 12'ha3, col_addr_out);
        cmd(8'h2d);
        chk("power", 12'h5, {booster_en_out, regulator_en_out, follower_en_out});
        cmd(8'h26);
        chk("ratio", 12'h6, resistor_ratio_out);
        cmd(8'h81);
        cmd(8'he2);
        chk("level", 12'h22, lcd_drive_level_out);
        chk("display_on", 12'h1, display_on_out);
        cmd(8'h40);
        chk("start_line", 12'h0, start_line_out);
        cmd(8'had);
        cmd(8'h81);
        chk("indicator", 12'h5, {indicator_on_out, indicator_blink_out});
        cmd(8'h81);
        cmd(8'hfe);
        chk("level", 12'h3e, {test_mode_out, lcd_drive_level_out});
        cmd(8'hac);
        chk("indicator_on", 12'h0, indicator_on_out);
        cmd(8'h3f);
        chk("nline", 12'h1f, {nline_active_out, nline_count_out});
        cmd(8'h30);
        chk("nline", 12'h00, {nline_active_out, nline_count_out});
        cmd(8'h3f);
        cmd(8'he4);
        chk("nline", 12'h0f, {nline_active_out, nline_count_out});
        cmd(8'hab);
        chk("osc_on", 12'h1, osc_on_out);
        cmd(8'h2f);
        cmd(8'ha9);
        chk("sleep", 12'h18, save_view);
        cmd(8'he1);
        chk("wake", 12'h07, save_view);
        cmd(8'ha8);
        chk("standby", 12'h11, save_view);
        cmd(8'he1);
        cmd(8'he5);
        chk("unknown", 12'h01, {start_line_out, display_on_out});
        cmd(8'hf3);
        chk("test_mode", 12'h1, test_mode_out);
        cmd(8'h45);
        chk("start_line", 12'h0, start_line_out);
        cmd(8'he3);
        chk("test_mode", 12'h0, test_mode_out);
        cmd(8'hf0);
        chip_reset_n_in = 1'b0;
        @(negedge clk_sys_in);
        chip_reset_n_in = 1'b1;
        chk("pin reset", 12'h0, {test_mode_out, display_on_out});
        cmd(8'hff);
        cmd(8'he2);
        chk("cmd reset", 12'h060, {test_mode_out, display_on_out, osc_on_out,
            lcd_drive_level_out});
        // Fill the queue under a memory stall, in read-modify-write.
        cmd(8'hb3);
        cmd(8'h12);
        cmd(8'h00);
        stall = 1'b1;
        cmd(8'he0);
        for (int i = 0; i < 8; i++)
            put(1'b1, 8'h10 + i[7:0]);
        chk("wr_ready", 12'h0, wr_ready_out);
        chk("col", 12'h28, col_addr_out);
        stall = 1'b0;
        drain;
        rd(8'hd7);
        chk("col", 12'h28, col_addr_out);
        cmd(8'hee);
        chk("col", 12'h020, {rmw_active_out, col_addr_out});
        for (int i = 0; i < 8; i++) begin
            cmd({4'h0, i[3:0]});
            rd(8'h10 + i[7:0]);
        end
        test_done;
    end
    // A hang is cut short well beyond the under two hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        test_done;
    end
endmodule // lcd_command_decoder_test
`default_nettype wire

//--- lcd_defines.vh
`ifndef LCD_DEFINES_VH
`define LCD_DEFINES_VH
// Full command codes.
`define LCD_CMD_DISP_OFF 8'hae
`define LCD_CMD_DISP_ON 8'haf
`define LCD_CMD_MAP_NORM 8'ha0
`define LCD_CMD_MAP_REV 8'ha1
`define LCD_CMD_BIAS_9 8'ha2
`define LCD_CMD_BIAS_7 8'ha3
`define LCD_CMD_ALL_NORM 8'ha4
`define LCD_CMD_ALL_ON 8'ha5
`define LCD_CMD_INV_NORM 8'ha6
`define LCD_CMD_INV_ON 8'ha7
`define LCD_CMD_SAVE_STBY 8'ha8
`define LCD_CMD_SAVE_SLEEP 8'ha9
`define LCD_CMD_OSC_ON 8'hab
`define LCD_CMD_IND_OFF 8'hac
`define LCD_CMD_IND_ON 8'had
`define LCD_CMD_LEVEL_MODE 8'h81
`define LCD_CMD_RMW 8'he0
`define LCD_CMD_SAVE_EXIT 8'he1
`define LCD_CMD_RESET 8'he2
`define LCD_CMD_NO_OP 8'he3
`define LCD_CMD_NLINE_OFF 8'he4
`define LCD_CMD_RMW_END 8'hee
// Prefix codes and their compare masks.
`define LCD_PFX_START 8'h40
`define LCD_MSK_START 8'hc0
`define LCD_PFX_PAGE 8'hb0
`define LCD_PFX_COLH 8'h10
`define LCD_PFX_COLL 8'h00
`define LCD_PFX_NLINE 8'h30
`define LCD_PFX_TEST 8'hf0
`define LCD_MSK_NIB 8'hf0
`define LCD_PFX_SCAN 8'hc0
`define LCD_PFX_PWR 8'h28
`define LCD_PFX_RATIO 8'h20
`define LCD_MSK_3B 8'hf8
// Reset values.
`define LCD_RST_LEVEL 6'h20
`define LCD_RST_RATIO 3'h0
`define LCD_RST_NLINE 4'h0
`endif

//--- lcd_fifo.v
`timescale 1ns/1ps
`default_nettype none
// Small flip-flop FIFO; the write queue between the bus and display memory.
module lcd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push, pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage has no reset; only pointers and count do.
    always @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // lcd_fifo
`default_nettype wire

//--- lcd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_mem_model #(
    parameter AW = 12
) (
    input wire logic clk_sys_in,
    input wire logic stall_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [7:0] wdata_in,
    output logic wready_out,
    input wire logic [AW-1:0] raddr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] store [0:(1<<AW)-1];
    // Unwritten cells read an address pattern, so a missed write never looks right.
    initial begin
        for (int i = 0; i < (1 << AW); i++)
            store[i] = ~i[7:0];
    end
    // The bench stalls the memory to back the write queue up.
    assign wready_out = !stall_in;
    assign rdata_out = store[raddr_in];
    always @(posedge clk_sys_in) begin
        if (we_in && wready_out)
            store[waddr_in] <= wdata_in;
    end
endmodule // lcd_mem_model
`default_nettype wire
